// File: design/rpt_ramp_pwm_timer.sv
// Ramp PWM timer with two fault or capture event inputs
`timescale 1ns/1ns
`include "rpt_regs.svh"
module rpt_ramp_pwm_timer
  import rpt_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Static configuration
  input  wire logic        enable,
  input  wire logic [1:0]  waveformSchemeSelect,
  input  wire rpt_evcfg_t  evCfgA,
  input  wire rpt_evcfg_t  evCfgB,
  input  wire rpt_dlycfg_t dlyCfg,
  // Buffered compare values
  input  wire rpt_cmp_t    cmpBuf,
  // Command strobes
  input  wire rpt_cmd_t    cmdStrobe,
  // Event inputs
  input  wire logic        eventInA,
  input  wire logic        eventInB,
  // Status
  output logic             enableReadyFlag,
  output logic             commandReady,
  output logic             timerRunning,
  output rpt_cnt_t         captureA,
  output rpt_cnt_t         captureB,
  // Waveform outputs
  output logic             waveformOutA,
  output logic             waveformOutB
);

  rpt_state_t             s;
  rpt_state_t             n;
  rpt_evcfg_t [1:0]       evCfg;
  logic       [1:0]       evRaw;
  logic       [1:0]       evLvl;
  logic       [1:0]       faultOn;
  logic       [1:0]       flowFault;
  logic       [1:0]       outKill;
  logic       [1:0]       killBoth;
  logic       [1:0]       haltReq;
  logic       [1:0]       capEdge;
  logic       [1:0]       outOn;
  logic       [1:0]       restSet;
  logic                   killA;
  logic                   killB;
  rpt_cmd_t               cmd;
  logic                   startEv;
  logic                   eoc;
  logic                   delay_trigger_select;
  logic       [2:0]       prescMask;
  rpt_cnt_t               initTop;

  assign evCfg[0] = evCfgA;
  assign evCfg[1] = evCfgB;
  assign evRaw    = {eventInB, eventInA};
  assign outOn    = {s.outB, s.outA};

  // ------------------------------------------------------------
  // Per-input event processing
  // ------------------------------------------------------------
  for (genvar gi = 0; gi < 2; gi++) begin : g_in
    logic masked;
    // Blanking only ever masks input A
    assign masked        = (gi == 0) & s.blank;
    // Async detection bypasses the filter
    assign evLvl[gi]     = (evCfg[gi].filter & ~evCfg[gi].asyncDet) ?
                           s.evFilt[gi] : s.evS2[gi];
    assign faultOn[gi]   = evCfg[gi].trigEn & ~evCfg[gi].action &
                           (evCfg[gi].mode != `RPT_MODE_OFF);
    assign flowFault[gi] = faultOn[gi] & evLvl[gi] & ~masked;
    // Async detection gates the outputs straight from the pin
    assign outKill[gi]   = faultOn[gi] & ~masked &
                           (evCfg[gi].asyncDet ? evRaw[gi] : evLvl[gi]);
    assign killBoth[gi]  = (evCfg[gi].mode >= `RPT_MODE_BOTH_LO) &
                           (evCfg[gi].mode <= `RPT_MODE_BOTH_HI);
    assign haltReq[gi]   = flowFault[gi] & (evCfg[gi].mode == `RPT_MODE_SW_WAIT);
    assign capEdge[gi]   = evCfg[gi].trigEn & evCfg[gi].action &
                           evLvl[gi] & ~s.evPrev[gi];
    // Output stays off for the rest of its on-time
    assign restSet[gi]   = outOn[gi] & faultOn[gi] &
                           (((evCfg[gi].mode == `RPT_MODE_EDGE_REST) &
                             evLvl[gi] & ~s.evPrev[gi] & ~masked) |
                            ((evCfg[gi].mode == `RPT_MODE_LVL_REST) & outKill[gi]));
  end

  assign killA = s.halt | s.restOff[0] | (outKill[0] & ~killBoth[0]) |
                 (outKill[0] & killBoth[0]) | (outKill[1] & killBoth[1]);
  assign killB = s.halt | s.restOff[1] | (outKill[1] & ~killBoth[1]) |
                 (outKill[1] & killBoth[1]) | (outKill[0] & killBoth[0]);

  assign prescMask = ~(`RPT_PRESC_ONES << dlyCfg.presc);
  assign cmd       = s.cmdPend;
  assign startEv   = s.enS2 & ~s.enPrev;
  assign initTop   = startEv ? cmpBuf.bClr : s.act.bClr;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n       = s;
    eoc     = 1'b0;
    delay_trigger_select = 1'b0;

    // Enable crosses into the core through two stages
    n.enS1   = enable;
    n.enS2   = s.enS1;
    n.enPrev = s.enS2;
    n.evS1   = evRaw;
    n.evS2   = s.evS1;
    n.evPrev = evLvl;

    for (int i = 0; i < 2; i++) begin
      if (s.evS2[i] == s.evFilt[i]) begin
        n.filtCnt[i] = '0;
      end else if (s.filtCnt[i] == `RPT_FILT_LAST) begin
        n.evFilt[i]  = s.evS2[i];
        n.filtCnt[i] = '0;
      end else begin
        n.filtCnt[i] = s.filtCnt[i] + 1'b1;
      end
    end

    // Strobes are held one cycle, then handed to the core
    if (commandReady) begin
      n.cmdPend = cmdStrobe;
    end else begin
      n.cmdPend = '0;
    end

    if (cmd.capA | capEdge[0]) begin
      n.capA = s.cnt;
    end
    if (cmd.capB | capEdge[1]) begin
      n.capB = s.cnt;
    end

    if (!s.enS2) begin
      n.run     = 1'b0;
      n.outA    = 1'b0;
      n.outB    = 1'b0;
      n.halt    = 1'b0;
      n.restOff = '0;
    end else if (startEv) begin
      n.run     = 1'b1;
      n.act     = cmpBuf;
      n.updPend = 1'b0;
      n.disPend = 1'b0;
      n.cnt     = (waveformSchemeSelect == `RPT_SCH_DUAL) ? initTop : '0;
      n.dirUp   = 1'b0;
      n.phase   = DEAD_A;
      n.outA    = 1'b0;
      n.outB    = 1'b0;
      n.halt    = 1'b0;
      n.restOff = '0;
    end else if (s.run) begin
      if (cmd.updNow) begin
        n.act = cmpBuf;
      end
      if (cmd.updEoc) begin
        n.updPend = 1'b1;
      end
      if (cmd.disable_end_cycle_strobe) begin
        n.disPend = 1'b1;
      end

      if (cmd.restart) begin
        n.cnt   = (waveformSchemeSelect == `RPT_SCH_DUAL) ? initTop : '0;
        n.dirUp = 1'b0;
        n.phase = DEAD_A;
        n.outA  = 1'b0;
        n.outB  = 1'b0;
        n.halt  = 1'b0;
      end else if (!s.halt) begin
        case (waveformSchemeSelect)
          `RPT_SCH_ONE: begin
            if (s.cnt == s.act.bClr) begin
              n.cnt  = '0;
              n.outA = 1'b0;
              n.outB = 1'b0;
              eoc    = 1'b1;
            end else begin
              n.cnt = s.cnt + 1'b1;
              if (s.cnt == s.act.aSet) begin
                n.outA = 1'b1;
              end
              if ((s.cnt == s.act.aClr) && (s.act.aClr >= s.act.aSet)) begin
                n.outA = 1'b0;
              end
              if (s.cnt == s.act.bSet) begin
                n.outB = 1'b1;
              end
            end
          end
          `RPT_SCH_TWO: begin
            if (s.phase == DEAD_A) begin
              if (s.cnt == s.act.aClr) begin
                n.cnt   = '0;
                n.outA  = 1'b0;
                n.phase = DEAD_B;
              end else begin
                n.cnt = s.cnt + 1'b1;
                if (s.cnt == s.act.aSet) begin
                  n.outA = 1'b1;
                end
              end
            end else begin
              if (s.cnt == s.act.bClr) begin
                n.cnt   = '0;
                n.outB  = 1'b0;
                n.phase = DEAD_A;
                eoc     = 1'b1;
              end else begin
                n.cnt = s.cnt + 1'b1;
                if (s.cnt == s.act.bSet) begin
                  n.outB = 1'b1;
                end
              end
            end
          end
          `RPT_SCH_FOUR: begin
            n.cnt = s.cnt + 1'b1;
            case (s.phase)
              DEAD_A: begin
                if (s.cnt == s.act.aSet) begin
                  n.cnt   = '0;
                  n.phase = ON_A;
                  n.outA  = 1'b1;
                end
              end
              ON_A: begin
                if (s.cnt == s.act.aClr) begin
                  n.cnt   = '0;
                  n.phase = DEAD_B;
                  n.outA  = 1'b0;
                end
              end
              DEAD_B: begin
                if (s.cnt == s.act.bSet) begin
                  n.cnt   = '0;
                  n.phase = ON_B;
                  n.outB  = 1'b1;
                end
              end
              ON_B: begin
                if (s.cnt == s.act.bClr) begin
                  n.cnt   = '0;
                  n.phase = DEAD_A;
                  n.outB  = 1'b0;
                  eoc     = 1'b1;
                end
              end
              default: begin
                n.cnt   = '0;
                n.phase = DEAD_A;
              end
            endcase
          end
          default: begin
            // A-clear takes no part in this scheme
            if (!s.dirUp) begin
              if (s.cnt == s.act.aSet) begin
                n.outA = 1'b1;
              end
              if (s.cnt == s.act.bSet) begin
                n.outB = 1'b0;
              end
              // Each end point is held for two clocks
              if (s.cnt == '0) begin
                n.dirUp = 1'b1;
              end else begin
                n.cnt = s.cnt - 1'b1;
              end
            end else begin
              if (s.cnt == s.act.aSet) begin
                n.outA = 1'b0;
              end
              if (s.cnt == s.act.bSet) begin
                n.outB = 1'b1;
              end
              if (s.cnt == s.act.bClr) begin
                n.dirUp = 1'b0;
                eoc     = 1'b1;
              end else begin
                n.cnt = s.cnt + 1'b1;
              end
            end
          end
        endcase
      end

      // Event set wins over restart
      if (|haltReq) begin
        n.halt = 1'b1;
      end

      if (eoc) begin
        if (s.updPend | cmd.updEoc) begin
          n.act     = cmpBuf;
          n.updPend = 1'b0;
        end
        if (s.disPend | cmd.disable_end_cycle_strobe) begin
          n.run     = 1'b0;
          n.disPend = 1'b0;
          n.outA    = 1'b0;
          n.outB    = 1'b0;
        end
      end
    end

    // ------------------------------------------------------------
    // Rest-of-on-time suppression
    // ------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      if (restSet[i]) begin
        n.restOff[i] = 1'b1;
      end else if (!outOn[i]) begin
        n.restOff[i] = 1'b0;
      end
    end

    // ------------------------------------------------------------
    // Input blanking on the prescaled delay clock
    // ------------------------------------------------------------
    case (dlyCfg.trig)
      `RPT_DTRIG_ASET: delay_trigger_select = n.outA & ~s.outA;
      `RPT_DTRIG_ACLR: delay_trigger_select = ~n.outA & s.outA;
      `RPT_DTRIG_BSET: delay_trigger_select = n.outB & ~s.outB;
      default:         delay_trigger_select = eoc;
    endcase

    if (delay_trigger_select && (dlyCfg.sel == `RPT_DSEL_BLANK)) begin
      n.blank    = 1'b1;
      n.blankCnt = '0;
      n.presc    = '0;
    end else if (s.blank) begin
      n.presc = s.presc + 1'b1;
      if (s.blankCnt == dlyCfg.value) begin
        n.blank = 1'b0;
      end else if ((s.presc & prescMask) == prescMask) begin
        n.presc    = '0;
        n.blankCnt = s.blankCnt + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s       <= '0;
      s.phase <= DEAD_A;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign enableReadyFlag = (s.enS1 == enable) & (s.enS2 == enable);
  assign commandReady    = ~|s.cmdPend;
  assign timerRunning    = s.run;
  assign captureA        = s.capA;
  assign captureB        = s.capB;
  assign waveformOutA    = s.outA & ~killA;
  assign waveformOutB    = s.outB & ~killB;

endmodule : rpt_ramp_pwm_timer

// File: inc/rpt_regs.svh
// Encodings, field codes and timing counts of the ramp PWM timer
`ifndef RPT_REGS_SVH
`define RPT_REGS_SVH

// ------------------------------------------------------------
// Counting schemes
// ------------------------------------------------------------
`define RPT_SCH_ONE        2'h0
`define RPT_SCH_TWO        2'h1
`define RPT_SCH_FOUR       2'h2
`define RPT_SCH_DUAL       2'h3

// ------------------------------------------------------------
// Fault input modes
// ------------------------------------------------------------
`define RPT_MODE_OFF       4'h0
`define RPT_MODE_BOTH_LO   4'h4
`define RPT_MODE_BOTH_HI   4'h7
`define RPT_MODE_SW_WAIT   4'h7
`define RPT_MODE_EDGE_REST 4'h9
`define RPT_MODE_LVL_REST  4'ha

// ------------------------------------------------------------
// Delay logic
// ------------------------------------------------------------
`define RPT_DSEL_BLANK     2'h1
`define RPT_DTRIG_ASET     2'h0
`define RPT_DTRIG_ACLR     2'h1
`define RPT_DTRIG_BSET     2'h2
`define RPT_DTRIG_CYCLE    2'h3
`define RPT_PRESC_ONES     3'h7

// ------------------------------------------------------------
// Digital filter: last count before the filtered level follows
// ------------------------------------------------------------
`define RPT_FILT_LAST      2'h3

`endif

// File: inc/rpt_pkg.sv
// Types shared by the ramp PWM timer
package rpt_pkg;

  localparam int CNT_W = 12;
  localparam int DLY_W = 8;

  typedef logic [CNT_W-1:0] rpt_cnt_t;

  typedef struct packed {
    rpt_cnt_t aSet;
    rpt_cnt_t aClr;
    rpt_cnt_t bSet;
    rpt_cnt_t bClr;
  } rpt_cmp_t;

  typedef struct packed {
    logic updEoc;
    logic updNow;
    logic restart;
    logic capA;
    logic capB;
    logic disable_end_cycle_strobe;
  } rpt_cmd_t;

  typedef struct packed {
    logic       trigEn;
    logic       action;
    logic       filter;
    logic       asyncDet;
    logic [3:0] mode;
  } rpt_evcfg_t;

  typedef struct packed {
    logic [1:0]       sel;
    logic [1:0]       trig;
    logic [1:0]       presc;
    logic [DLY_W-1:0] value;
  } rpt_dlycfg_t;

  typedef enum logic [3:0] {
    DEAD_A = 4'b0001,
    ON_A   = 4'b0010,
    DEAD_B = 4'b0100,
    ON_B   = 4'b1000
  } rpt_phase_t;

  typedef struct packed {
    logic             enS1;
    logic             enS2;
    logic             enPrev;
    logic             run;
    rpt_cmd_t         cmdPend;
    rpt_cmp_t         act;
    logic             updPend;
    logic             disPend;
    rpt_cnt_t         cnt;
    logic             dirUp;
    rpt_phase_t       phase;
    logic             outA;
    logic             outB;
    logic             halt;
    logic [1:0]       evS1;
    logic [1:0]       evS2;
    logic [1:0]       evFilt;
    logic [1:0][1:0]  filtCnt;
    logic [1:0]       evPrev;
    logic [1:0]       restOff;
    logic             blank;
    logic [DLY_W-1:0] blankCnt;
    logic [2:0]       presc;
    rpt_cnt_t         capA;
    rpt_cnt_t         capB;
  } rpt_state_t;

endpackage : rpt_pkg

// File: sim/rpt_event_src.sv
// Event system model driving one timer event input
`timescale 1ns/1ns
module rpt_event_src (
  // Clock and request
  input  wire logic       ref_clk,
  input  wire logic       pulseReq,
  input  wire logic [4:0] pulseLen,
  // Event line
  output logic            eventOut
);
  logic [4:0] left_r = 5'h00;
  // Line is low between pulses; a request sets the pulse length in clocks
  always @(posedge ref_clk) begin
    if (pulseReq) left_r <= pulseLen;
    else if (left_r != 5'h00) left_r <= left_r - 5'h01;
  end
  assign eventOut = (left_r != 5'h00);
endmodule : rpt_event_src

// File: sim/rpt_timer_props.sv
// Port assertions of the ramp PWM timer
`timescale 1ns/1ns
module rpt_timer_props
  import rpt_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Controls
  input wire logic        enable,
  input wire logic [1:0]  waveformSchemeSelect,
  input wire rpt_evcfg_t  evCfgA,
  input wire rpt_dlycfg_t dlyCfg,
  input wire rpt_cmd_t    cmdStrobe,
  input wire logic        eventInA,
  // Status and outputs
  input wire logic        enableReadyFlag,
  input wire logic        commandReady,
  input wire logic        timerRunning,
  input wire logic        waveformOutA,
  input wire logic        waveformOutB
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic killA;
  // Input A set to kill both outputs, blanking off
  assign killA = evCfgA.trigEn && !evCfgA.action && evCfgA.mode == 4'h4 && dlyCfg.sel != 2'h1;
  a_cmd_one_cycle: assert property (
    commandReady && |cmdStrobe |=> !commandReady ##1 commandReady)
    else $error("command ready low not one cycle");
  a_ready_flag_sync: assert property (
    $changed(enable) |-> !enableReadyFlag ##2 enableReadyFlag)
    else $error("enable ready flag timing wrong");
  a_enable_start: assert property (
    $rose(enable) |-> ##[1:5] timerRunning)
    else $error("timer did not start");
  a_enable_stop: assert property (
    $fell(enable) |-> ##[1:5] !timerRunning)
    else $error("timer did not stop");
  a_stopped_outs_low: assert property (
    !timerRunning && !$past(timerRunning) |-> !waveformOutA && !waveformOutB)
    else $error("outputs active while stopped");
  a_ramp_no_overlap: assert property (
    waveformSchemeSelect inside {2'h1, 2'h2} |-> !(waveformOutA && waveformOutB))
    else $error("outputs overlap");
  a_kill_sync_path: assert property (
    (killA && !evCfgA.filter && !evCfgA.asyncDet && eventInA) [*4]
    |-> !waveformOutA && !waveformOutB)
    else $error("synced fault did not kill outputs");
  a_kill_async_now: assert property (
    killA && evCfgA.asyncDet && eventInA |-> !waveformOutA && !waveformOutB)
    else $error("async fault did not kill outputs");
endmodule : rpt_timer_props
bind rpt_ramp_pwm_timer rpt_timer_props rpt_timer_props_inst (
  .ref_clk, .resetn, .enable, .waveformSchemeSelect, .evCfgA, .dlyCfg, .cmdStrobe,
  .eventInA, .enableReadyFlag, .commandReady, .timerRunning, .waveformOutA, .waveformOutB);

// File: sim/rpt_ramp_pwm_timer_tb.sv
// Self-checking bench of the ramp PWM timer
`timescale 1ns/1ns
`include "rpt_regs.svh"
module rpt_ramp_pwm_timer_tb;
  import rpt_pkg::*;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        enable = 1'b0;
  logic [1:0]  scheme = 2'h0;
  rpt_evcfg_t  evCfgA = '0;
  rpt_evcfg_t  evCfgB = '0;
  rpt_dlycfg_t dlyCfg = '0;
  rpt_cmp_t    cmpBuf = '0;
  rpt_cmp_t    c;
  rpt_cmd_t    cmdStrobe = '0;
  logic        reqA = 1'b0;
  logic        reqB = 1'b0;
  logic [4:0]  evLen = 5'h00;
  logic        eventInA;
  logic        eventInB;
  logic        enableReadyFlag;
  logic        commandReady;
  logic        timerRunning;
  logic        waveformOutA;
  logic        waveformOutB;
  logic        prevB = 1'b0;
  logic        measOn = 1'b0;
  logic        killed;
  rpt_cnt_t    captureA;
  rpt_cnt_t    captureB;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          lastRise = -1;
  int          per;
  int          expQ[$];
  logic [7:0]  aCfg [6] = '{8'h84, 8'h04, 8'hc4, 8'ha4, 8'ha4, 8'h94};
  logic [4:0]  aLen [6] = '{5'h05, 5'h08, 5'h08, 5'h03, 5'h08, 5'h04};
  logic        aExp [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  always #20 ref_clk = ~ref_clk;
  rpt_ramp_pwm_timer rpt_ramp_pwm_timer_inst (.ref_clk, .resetn, .enable,
    .waveformSchemeSelect(scheme), .evCfgA, .evCfgB, .dlyCfg, .cmpBuf, .cmdStrobe,
    .eventInA, .eventInB, .enableReadyFlag, .commandReady, .timerRunning, .captureA,
    .captureB, .waveformOutA, .waveformOutB);
  rpt_event_src rpt_event_src_a_inst (.ref_clk, .pulseReq(reqA), .pulseLen(evLen),
    .eventOut(eventInA));
  rpt_event_src rpt_event_src_b_inst (.ref_clk, .pulseReq(reqB), .pulseLen(evLen),
    .eventOut(eventInB));
  // Period between rising edges of output B, checked against the oldest note
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prevB <= waveformOutB;
    if (measOn && waveformOutB && !prevB) begin
      if (lastRise >= 0 && expQ.size() > 0) `CHK(cyc - lastRise, expQ.pop_front())
      lastRise <= cyc;
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    for (int n = 0; n < lim && sig !== lvl; n++) @(posedge ref_clk);
    if (sig !== lvl) begin
      error_cnt++;
      give_verdict();
    end
  endtask : wait_for
  task automatic start(input logic [1:0] sch, input rpt_cmp_t cv);
    scheme <= sch;
    cmpBuf <= cv;
    wait_for(enableReadyFlag, 1'b1, 8);
    enable <= 1'b1;
    @(posedge ref_clk);
    wait_for(timerRunning, 1'b1, 8);
  endtask : start
  task automatic stop();
    wait_for(enableReadyFlag, 1'b1, 8);
    enable <= 1'b0;
    @(posedge ref_clk);
    wait_for(timerRunning, 1'b0, 8);
  endtask : stop
  // Strobe lasts one clock; the extra edge keeps two strobes apart
  task automatic cmd(input rpt_cmd_t cc);
    wait_for(commandReady, 1'b1, 8);
    cmdStrobe <= cc;
    @(posedge ref_clk);
    cmdStrobe <= '0;
    @(posedge ref_clk);
  endtask : cmd
  task automatic pulse(input logic onB, input logic [4:0] len);
    evLen <= len;
    reqA <= !onB;
    reqB <= onB;
    @(posedge ref_clk);
    reqA <= 1'b0;
    reqB <= 1'b0;
  endtask : pulse
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(73825));
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (int s = 0; s < 4; s++) begin
      c.aSet = rpt_cnt_t'($urandom_range(6, 2));
      c.aClr = c.aSet + rpt_cnt_t'($urandom_range(6, 2));
      c.bSet = c.aClr + rpt_cnt_t'($urandom_range(6, 2));
      c.bClr = c.bSet + rpt_cnt_t'($urandom_range(6, 2));
      case (s)
        0: per = c.bClr + 1;
        1: per = c.aClr + c.bClr + 2;
        2: per = c.aSet + c.aClr + c.bSet + c.bClr + 4;
        default: per = 2 * (c.bClr + 1);
      endcase
      start(2'(s), c);
      lastRise = -1;
      expQ = '{per, per};
      measOn = 1'b1;
      for (int n = 0; n < 300 && expQ.size() > 0; n++) @(posedge ref_clk);
      if (expQ.size() > 0) begin
        error_cnt++;
        give_verdict();
      end
      measOn = 1'b0;
      stop();
      $display("scheme %0d period test done", s);
    end
    c = '{12'h001, 12'h002, 12'h003, 12'h028};
    // Modes 0..10 on input B, then input A options, all during on-time B
    for (int i = 0; i < 17; i++) begin
      evCfgA <= (i < 11) ? '0 : aCfg[i-11];
      evCfgB <= (i < 11) ? rpt_evcfg_t'({4'h8, 4'(i)}) : '0;
      start(`RPT_SCH_FOUR, c);
      wait_for(waveformOutB, 1'b0, 200);
      wait_for(waveformOutB, 1'b1, 200);
      repeat (3) @(posedge ref_clk);
      pulse(i < 11, (i < 11) ? 5'h05 : aLen[i-11]);
      killed = 1'b0;
      repeat (14) begin
        @(posedge ref_clk);
        if (waveformOutB !== 1'b1) killed = 1'b1;
      end
      `CHK(killed, (i < 11) ? (i != 0) : aExp[i-11])
      cmd('{restart: 1'b1, default: 1'b0});
      wait_for(waveformOutB, 1'b1, 100);
      stop();
      $display("fault case %0d done", i);
    end
    evCfgA <= '0;
    evCfgB <= '0;
    start(`RPT_SCH_ONE, c);
    cmd('{capA: 1'b1, default: 1'b0});
    repeat (39) @(posedge ref_clk);
    cmd('{capB: 1'b1, default: 1'b0});
    repeat (3) @(posedge ref_clk);
    `CHK(captureB, captureA)
    `CHK(captureA <= 12'h028, 1'b1)
    wait_for(waveformOutB, 1'b0, 100);
    wait_for(waveformOutB, 1'b1, 100);
    cmd('{disable_end_cycle_strobe: 1'b1, default: 1'b0});
    repeat (5) @(posedge ref_clk);
    `CHK(timerRunning, 1'b1)
    wait_for(timerRunning, 1'b0, 60);
    enable <= 1'b0;
    repeat (4) @(posedge ref_clk);
    $display("capture and stop test done");
    give_verdict();
  end
endmodule : rpt_ramp_pwm_timer_tb
